// ==== pfps_pkg_sync.sv ====
// Constants, carrier types and the link input synchroniser
`timescale 1ns/1ps
// ****************************************************************
// Package
// ****************************************************************
package pfps_pkg;
  localparam logic [31:0] BUFFER_RAM_BASE = 32'h1400_0000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int LOCKUP_TIME_NS = 4000;
  localparam int LOCKUP_CYCLES =
    (LOCKUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_W = 24;
  localparam int LOCK_CNT_W = 12;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_BUFFER = 8'h02;
  localparam logic [7:0] CMD_SECTION_PROGRAM = 8'h03;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] CMD_MASS_ERASE = 8'hC7;
  localparam logic [7:0] CMD_MODE_EEPROM = 8'h20;
  localparam logic [7:0] CMD_MODE_RAM = 8'h21;
  localparam logic [7:0] CMD_SWAP = 8'h30;
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h40;
  localparam int ST_BIT_WIP = 0;
  localparam int ST_BIT_EEPROM = 1;
  localparam int ST_BIT_LOCKED = 2;
  localparam int ST_BIT_PRIV = 3;
  localparam int ST_BIT_ACCERR = 4;
  localparam int ST_BIT_SWAP_PEND = 5;
  localparam int ST_BIT_SWAP_ACT = 6;
  localparam int FLASH_BLOCK_BIT = 23;
  localparam int SECTOR_LSB = 12;
  localparam logic [11:0] SWAP_IND_SECTOR = 12'h7FF;
  localparam logic [1:0] SWAP_ST_UNINIT = 2'h0;
  localparam logic RST_EEPROM_MODE = 1'b0;
  localparam logic RST_SWAP = 1'b0;

  typedef enum logic [1:0] {
    PFPS_OP_PROGRAM = 2'b00,
    PFPS_OP_ERASE = 2'b01,
    PFPS_OP_MASS = 2'b10
  } pfps_op_t;

  typedef struct packed {
    logic valid;
    pfps_op_t op;
    logic [23:0] addr;
  } pfps_flash_cmd_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [7:0] data;
  } pfps_ram_wr_t;
endpackage

// ****************************************************************
// Two-flop synchroniser
// ****************************************************************
module pfps_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule

// ==== pfps_prog_model.sv ====
// Programmer-side model driving the serial programming port
`timescale 1ns/1ps
module pfps_prog_model (
  output logic clk_o,
  output logic sel_n_o,
  output logic dat_o,
  input wire logic dat_i
);
  logic [7:0] rx;
  initial begin
    clk_o = 1'b0;
    sel_n_o = 1'b1;
    dat_o = 1'b0;
    rx = 8'h00;
  end
  // One selected frame, MSB first, clock still outside frames
  task automatic frame(input logic [63:0] v, input int n);
    sel_n_o = 1'b0;
    #62.5;
    for (int k = n - 1; k >= 0; k--) begin
      dat_o = v[k];
      #62.5 clk_o = 1'b1;
      rx = {rx[6:0], dat_i};
      #62.5 clk_o = 1'b0;
    end
    #62.5 sel_n_o = 1'b1;
    dat_o = ~dat_o;
    #250;
  endtask
endmodule

// ==== pfps_seq.sv ====
// Target-side serial programming port sequencer with swap and security
`timescale 1ns/1ps
module pfps_seq
  import pfps_pkg::*;
#(
  parameter int LOCKUP_CNT = LOCKUP_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic prog_port_clock_i,
  input wire logic prog_port_select_n_i,
  input wire logic prog_port_data_in_i,
  output logic prog_port_data_out_o,
  input wire logic cfg_secure_i,
  input wire logic cfg_mass_erase_dis_i,
  input wire logic cfg_backdoor_dis_i,
  input wire logic swap_enable_i,
  input wire logic [1:0] swap_state_i,
  input wire logic boot_i,
  input wire logic flash_blank_i,
  input wire logic core_halt_req_i,
  output pfps_pkg::pfps_flash_cmd_t flash_cmd_o,
  input wire logic command_complete_flag_i,
  output pfps_pkg::pfps_ram_wr_t buffer_ram_wr_o,
  output logic buffer_ram_eeprom_mode_o,
  output logic flash_block_swap_o,
  output logic write_in_progress_o,
  output logic privilege_violation_o,
  output logic access_error_o,
  output logic prog_locked_o,
  output logic core_lockup_reset_o
);
  import pfps_pkg::*;

  // ****************************************************************
  // Link input synchronisation and edge detection
  // ****************************************************************
  logic [2:0] link_q;
  logic s_clk;
  logic s_sel_n;
  logic s_din;
  logic clk_d_r;
  logic rise;
  logic fall;

  pfps_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i({prog_port_clock_i, prog_port_select_n_i, prog_port_data_in_i}),
    .q_o(link_q)
  );

  assign s_clk = link_q[2];
  assign s_sel_n = link_q[1];
  assign s_din = link_q[0];

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= s_clk;
    end
  end

  assign rise = s_clk & ~clk_d_r;
  assign fall = ~s_clk & clk_d_r;

  // ****************************************************************
  // Command state machine
  // ****************************************************************
  typedef enum logic [2:0] {
    PFPS_IDLE = 3'b000,
    PFPS_ADDR = 3'b001,
    PFPS_DATA = 3'b010,
    PFPS_STAT = 3'b011,
    PFPS_DONE = 3'b100
  } pfps_state_t;

  pfps_state_t st_r, st_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic dout_r, dout_nxt;
  logic busy_r, busy_nxt;
  logic eeprom_r, eeprom_nxt;
  logic priv_r, priv_nxt;
  logic accerr_r, accerr_nxt;
  logic swp_pend_r, swp_pend_nxt;
  logic swp_act_r, swp_act_nxt;
  pfps_flash_cmd_t fcmd_r, fcmd_nxt;
  pfps_ram_wr_t rwr_r, rwr_nxt;
  logic locked;
  logic [7:0] status;
  logic [7:0] cmd_in;
  logic [23:0] addr_in;
  logic [7:0] data_in;

  assign locked = cfg_secure_i & cfg_mass_erase_dis_i
                  & cfg_backdoor_dis_i;
  assign cmd_in = {cmd_r[6:0], s_din};
  assign addr_in = {addr_r[22:0], s_din};
  assign data_in = {data_r[6:0], s_din};

  always_comb begin
    status = 8'h00;
    status[ST_BIT_WIP] = busy_r;
    status[ST_BIT_EEPROM] = eeprom_r;
    status[ST_BIT_LOCKED] = locked;
    status[ST_BIT_PRIV] = priv_r;
    status[ST_BIT_ACCERR] = accerr_r;
    status[ST_BIT_SWAP_PEND] = swp_pend_r;
    status[ST_BIT_SWAP_ACT] = swp_act_r;
  end

  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    tx_nxt = tx_r;
    dout_nxt = dout_r;
    busy_nxt = busy_r;
    eeprom_nxt = eeprom_r;
    priv_nxt = priv_r;
    accerr_nxt = accerr_r;
    swp_pend_nxt = swp_pend_r;
    swp_act_nxt = swp_act_r;
    fcmd_nxt = fcmd_r;
    fcmd_nxt.valid = 1'b0;
    rwr_nxt = rwr_r;
    rwr_nxt.valid = 1'b0;
    if (busy_r && command_complete_flag_i) begin
      busy_nxt = 1'b0;
    end
    if (boot_i) begin
      swp_act_nxt = swp_pend_r;
    end
    if (s_sel_n) begin
      st_nxt = PFPS_IDLE;
      cnt_nxt = 5'h00;
      cmd_nxt = 8'h00;
    end else if (rise) begin
      cnt_nxt = cnt_r + 5'h01;
      case (st_r)
        PFPS_IDLE: begin
          cmd_nxt = cmd_in;
          if (cnt_r == 5'h07) begin
            cnt_nxt = 5'h00;
            st_nxt = PFPS_DONE;
            case (cmd_in)
              CMD_READ_STATUS: begin
                tx_nxt = status;
                st_nxt = PFPS_STAT;
              end
              CMD_WRITE_BUFFER, CMD_SECTION_PROGRAM,
              CMD_SECTOR_ERASE: begin
                st_nxt = PFPS_ADDR;
              end
              CMD_MASS_ERASE: begin
                if (busy_r || locked) begin
                  accerr_nxt = 1'b1;
                end else begin
                  fcmd_nxt.valid = 1'b1;
                  fcmd_nxt.op = PFPS_OP_MASS;
                  fcmd_nxt.addr = 24'h000000;
                  busy_nxt = 1'b1;
                  swp_pend_nxt = 1'b0;
                end
              end
              CMD_MODE_EEPROM: begin
                if (busy_r) begin
                  accerr_nxt = 1'b1;
                end else begin
                  eeprom_nxt = 1'b1;
                end
              end
              CMD_MODE_RAM: begin
                if (busy_r) begin
                  accerr_nxt = 1'b1;
                end else begin
                  eeprom_nxt = 1'b0;
                end
              end
              CMD_SWAP: begin
                if (!swap_enable_i || locked || busy_r) begin
                  accerr_nxt = 1'b1;
                end else begin
                  swp_pend_nxt = ~swp_pend_r;
                end
              end
              CMD_CLEAR_FLAGS: begin
                priv_nxt = 1'b0;
                accerr_nxt = 1'b0;
              end
              default: begin
                st_nxt = PFPS_DONE;
              end
            endcase
          end
        end
        PFPS_ADDR: begin
          addr_nxt = addr_in;
          if (cnt_r == 5'h17) begin
            cnt_nxt = 5'h00;
            st_nxt = PFPS_DONE;
            if (cmd_r == CMD_WRITE_BUFFER) begin
              st_nxt = PFPS_DATA;
            end else if (busy_r || locked) begin
              accerr_nxt = 1'b1;
            end else if (cmd_r == CMD_SECTION_PROGRAM) begin
              if (eeprom_r) begin
                accerr_nxt = 1'b1;
              end else begin
                fcmd_nxt.valid = 1'b1;
                fcmd_nxt.op = PFPS_OP_PROGRAM;
                fcmd_nxt.addr = addr_in;
                fcmd_nxt.addr[FLASH_BLOCK_BIT] =
                  addr_in[FLASH_BLOCK_BIT] ^ swp_act_r;
                busy_nxt = 1'b1;
              end
            end else if (swap_enable_i && swap_state_i != SWAP_ST_UNINIT
                && addr_in[23:SECTOR_LSB] == SWAP_IND_SECTOR) begin
              priv_nxt = 1'b1;
            end else begin
              fcmd_nxt.valid = 1'b1;
              fcmd_nxt.op = PFPS_OP_ERASE;
              fcmd_nxt.addr = addr_in;
              fcmd_nxt.addr[FLASH_BLOCK_BIT] =
                addr_in[FLASH_BLOCK_BIT] ^ swp_act_r;
              busy_nxt = 1'b1;
            end
          end
        end
        PFPS_DATA: begin
          data_nxt = data_in;
          if (cnt_r == 5'h07) begin
            cnt_nxt = 5'h00;
            addr_nxt = addr_r + 24'h000001;
            if (busy_r || locked) begin
              accerr_nxt = 1'b1;
            end else begin
              rwr_nxt.valid = 1'b1;
              rwr_nxt.addr = BUFFER_RAM_BASE | {8'h00, addr_r};
              rwr_nxt.data = data_in;
            end
          end
        end
        PFPS_STAT: begin
          cnt_nxt = cnt_r;
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end else if (fall && st_r == PFPS_STAT) begin
      dout_nxt = tx_r[7];
      tx_nxt = {tx_r[6:0], tx_r[7]};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_r <= PFPS_IDLE;
      cmd_r <= 8'h00;
      cnt_r <= 5'h00;
      addr_r <= 24'h000000;
      data_r <= 8'h00;
      tx_r <= 8'h00;
      dout_r <= 1'b0;
      busy_r <= 1'b0;
      eeprom_r <= RST_EEPROM_MODE;
      priv_r <= 1'b0;
      accerr_r <= 1'b0;
      swp_pend_r <= RST_SWAP;
      swp_act_r <= RST_SWAP;
      fcmd_r <= '0;
      rwr_r <= '0;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      tx_r <= tx_nxt;
      dout_r <= dout_nxt;
      busy_r <= busy_nxt;
      eeprom_r <= eeprom_nxt;
      priv_r <= priv_nxt;
      accerr_r <= accerr_nxt;
      swp_pend_r <= swp_pend_nxt;
      swp_act_r <= swp_act_nxt;
      fcmd_r <= fcmd_nxt;
      rwr_r <= rwr_nxt;
    end
  end

  // ****************************************************************
  // Core lockup reset of a blank, unhalted device
  // ****************************************************************
  logic [LOCK_CNT_W-1:0] lock_cnt_r, lock_cnt_nxt;
  logic lockup_r, lockup_nxt;

  always_comb begin
    lock_cnt_nxt = {LOCK_CNT_W{1'b0}};
    lockup_nxt = 1'b0;
    if (flash_blank_i && !core_halt_req_i) begin
      if (lock_cnt_r == LOCK_CNT_W'(LOCKUP_CNT - 1)) begin
        lockup_nxt = 1'b1;
      end else begin
        lock_cnt_nxt = lock_cnt_r + LOCK_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      lock_cnt_r <= {LOCK_CNT_W{1'b0}};
      lockup_r <= 1'b0;
    end else begin
      lock_cnt_r <= lock_cnt_nxt;
      lockup_r <= lockup_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prog_port_data_out_o = dout_r;
  assign flash_cmd_o = fcmd_r;
  assign buffer_ram_wr_o = rwr_r;
  assign buffer_ram_eeprom_mode_o = eeprom_r;
  assign flash_block_swap_o = swp_act_r;
  assign write_in_progress_o = busy_r;
  assign privilege_violation_o = priv_r;
  assign access_error_o = accerr_r;
  assign prog_locked_o = locked;
  assign core_lockup_reset_o = lockup_r;
endmodule

// ==== pfps_seq_checker.sv ====
// Port assertions for the programming port sequencer
`timescale 1ns/1ps
module pfps_seq_checker
  import pfps_pkg::*;
#(
  parameter int LOCKUP_CNT = LOCKUP_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic cfg_secure_i,
  input wire logic cfg_mass_erase_dis_i,
  input wire logic cfg_backdoor_dis_i,
  input wire logic swap_enable_i,
  input wire logic [1:0] swap_state_i,
  input wire logic boot_i,
  input wire logic flash_blank_i,
  input wire logic core_halt_req_i,
  input wire pfps_pkg::pfps_flash_cmd_t flash_cmd_o,
  input wire logic command_complete_flag_i,
  input wire pfps_pkg::pfps_ram_wr_t buffer_ram_wr_o,
  input wire logic buffer_ram_eeprom_mode_o,
  input wire logic flash_block_swap_o,
  input wire logic write_in_progress_o,
  input wire logic privilege_violation_o,
  input wire logic prog_locked_o,
  input wire logic core_lockup_reset_o
);
  logic [15:0] run_r;
  logic [15:0] run_nxt;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Cycles of free-running blank core since last lockup pulse
  always_comb begin
    run_nxt = '0;
    if (flash_blank_i && !core_halt_req_i && !core_lockup_reset_o) begin
      run_nxt = run_r + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    run_r <= sys_rst_i ? '0 : run_nxt;
  end
  a_lock_and: assert property (prog_locked_o == (cfg_secure_i &&
    cfg_mass_erase_dis_i && cfg_backdoor_dis_i)) else $error("lock AND");
  a_locked_quiet: assert property ($past(prog_locked_o) |->
    !flash_cmd_o.valid && !buffer_ram_wr_o.valid) else $error("locked op");
  a_swap_on_boot: assert property (!$past(boot_i) |->
    $stable(flash_block_swap_o)) else $error("swap without boot");
  a_priv_cause: assert property ($rose(privilege_violation_o) |->
    $past(swap_enable_i) && $past(swap_state_i) != SWAP_ST_UNINIT)
    else $error("priv without swap");
  a_priv_no_cmd: assert property (privilege_violation_o &&
    !$past(privilege_violation_o) |-> !flash_cmd_o.valid)
    else $error("priv with command");
  a_wip_set: assert property (flash_cmd_o.valid |=>
    write_in_progress_o) else $error("wip not set");
  a_wip_clear: assert property (write_in_progress_o &&
    command_complete_flag_i |=> !write_in_progress_o)
    else $error("wip not cleared");
  a_no_prog_eeprom: assert property (flash_cmd_o.valid &&
    $past(buffer_ram_eeprom_mode_o) |-> flash_cmd_o.op != PFPS_OP_PROGRAM)
    else $error("program in eeprom mode");
  a_ram_base: assert property (buffer_ram_wr_o.valid |->
    buffer_ram_wr_o.addr[31:24] == BUFFER_RAM_BASE[31:24])
    else $error("buffer address");
  a_lockup_cause: assert property (core_lockup_reset_o |->
    $past(flash_blank_i) && !$past(core_halt_req_i)) else $error("lockup");
  a_lockup_bound: assert property (run_r <= LOCKUP_CNT + 3)
    else $error("lockup late");
endmodule
bind pfps_seq pfps_seq_checker #(.LOCKUP_CNT(LOCKUP_CNT)) chk_i (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .cfg_secure_i(cfg_secure_i), .cfg_mass_erase_dis_i(cfg_mass_erase_dis_i),
  .cfg_backdoor_dis_i(cfg_backdoor_dis_i), .swap_enable_i(swap_enable_i),
  .swap_state_i(swap_state_i), .boot_i(boot_i),
  .flash_blank_i(flash_blank_i), .core_halt_req_i(core_halt_req_i),
  .flash_cmd_o(flash_cmd_o), .buffer_ram_wr_o(buffer_ram_wr_o),
  .command_complete_flag_i(command_complete_flag_i),
  .buffer_ram_eeprom_mode_o(buffer_ram_eeprom_mode_o),
  .flash_block_swap_o(flash_block_swap_o),
  .write_in_progress_o(write_in_progress_o),
  .privilege_violation_o(privilege_violation_o),
  .prog_locked_o(prog_locked_o), .core_lockup_reset_o(core_lockup_reset_o));

// ==== test_pfps_seq.sv ====
// Self-checking bench for the programming port sequencer
`timescale 1ns/1ps
module test_pfps_seq;
  import pfps_pkg::*;
  logic sys_clk_i, sys_rst_i, pclk, psel_n, pdin, pdout;
  logic sec, me_dis, bd_dis, swap_en, boot, blank, halt, ccf;
  logic [1:0] swap_st;
  logic eep, swp, write_in_progress, priv, acc, locked, lockup;
  pfps_flash_cmd_t cmd;
  pfps_ram_wr_t wr;
  pfps_flash_cmd_t cmd_q[$];
  pfps_ram_wr_t wr_q[$];
  int err_total = 0;
  int samples_checked = 0;
  int n;
  pfps_prog_model prog_i (.clk_o(pclk), .sel_n_o(psel_n), .dat_o(pdin),
    .dat_i(pdout));
  pfps_seq #(.LOCKUP_CNT(8)) pfps_seq_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .prog_port_clock_i(pclk), .prog_port_select_n_i(psel_n),
    .prog_port_data_in_i(pdin), .prog_port_data_out_o(pdout),
    .cfg_secure_i(sec), .cfg_mass_erase_dis_i(me_dis),
    .cfg_backdoor_dis_i(bd_dis), .swap_enable_i(swap_en),
    .swap_state_i(swap_st), .boot_i(boot), .flash_blank_i(blank),
    .core_halt_req_i(halt), .flash_cmd_o(cmd),
    .command_complete_flag_i(ccf), .buffer_ram_wr_o(wr),
    .buffer_ram_eeprom_mode_o(eep), .flash_block_swap_o(swp),
    .write_in_progress_o(write_in_progress), .privilege_violation_o(priv),
    .access_error_o(acc), .prog_locked_o(locked),
    .core_lockup_reset_o(lockup));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (cmd.valid === 1'b1) cmd_q.push_back(cmd);
    if (wr.valid === 1'b1) wr_q.push_back(wr);
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stat(input logic [7:0] exp);
    prog_i.frame({8'h05, 8'h00}, 16);
    chk(prog_i.rx, exp);
  endtask
  // Pops one flash command; mass erase address is not compared
  task automatic got_cmd(input pfps_op_t op, input logic [23:0] a);
    pfps_flash_cmd_t c;
    c = '0;
    if (cmd_q.size() > 0) c = cmd_q.pop_front();
    if (op == PFPS_OP_MASS) c.addr = a;
    chk({c.valid, c.op, c.addr}, {1'b1, op, a});
  endtask
  task automatic got_wr(input logic [31:0] a, input logic [7:0] d);
    pfps_ram_wr_t w;
    w = '0;
    if (wr_q.size() > 0) w = wr_q.pop_front();
    chk({w.addr, w.data}, {a, d});
  endtask
  // Ends the running flash command and polls busy to zero
  task automatic done_cmd;
    logic [7:0] s;
    int k;
    chk(write_in_progress, 1);
    @(negedge sys_clk_i) ccf = 1'b1;
    @(negedge sys_clk_i) ccf = 1'b0;
    k = 0;
    s = 8'hFF;
    while (s[ST_BIT_WIP] !== 1'b0 && k < 8) begin
      prog_i.frame({8'h05, 8'h00}, 16);
      s = prog_i.rx;
      k++;
    end
    chk(s[ST_BIT_WIP], 0);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    summarize();
  end
  initial begin
    sys_rst_i = 1'b1;
    {sec, me_dis, bd_dis, swap_en, boot, blank, ccf} = '0;
    swap_st = 2'h0;
    halt = 1'b1;
    repeat (12) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    stat(8'h00);
    prog_i.frame(8'h20, 8);
    chk(eep, 1);
    stat(8'h02);
    prog_i.frame({8'h02, 24'h000010, 8'hA5, 8'h3C}, 48);
    got_wr(32'h1400_0010, 8'hA5);
    got_wr(32'h1400_0011, 8'h3C);
    prog_i.frame({8'h03, 24'h001000}, 32);
    chk({acc, 39'(cmd_q.size())}, {1'b1, 39'h0});
    prog_i.frame(8'h40, 8);
    prog_i.frame(8'h21, 8);
    chk(eep, 0);
    stat(8'h00);
    prog_i.frame({8'h03, 24'h001000}, 32);
    got_cmd(PFPS_OP_PROGRAM, 24'h001000);
    done_cmd();
    @(negedge sys_clk_i);
    swap_en = 1'b1;
    swap_st = 2'h1;
    prog_i.frame({8'hD8, 24'h7FF000}, 32);
    chk({priv, 39'(cmd_q.size())}, {1'b1, 39'h0});
    prog_i.frame(8'h40, 8);
    prog_i.frame(8'h30, 8);
    stat(8'h20);
    prog_i.frame(8'hC7, 8);
    got_cmd(PFPS_OP_MASS, 24'h000000);
    done_cmd();
    stat(8'h00);
    prog_i.frame(8'h30, 8);
    chk(swp, 0);
    @(negedge sys_clk_i) boot = 1'b1;
    @(negedge sys_clk_i) boot = 1'b0;
    @(negedge sys_clk_i);
    chk(swp, 1);
    prog_i.frame({8'hD8, 24'h001000}, 32);
    got_cmd(PFPS_OP_ERASE, 24'h801000);
    done_cmd();
    @(negedge sys_clk_i);
    {sec, me_dis, bd_dis} = 3'h7;
    @(negedge sys_clk_i);
    chk(locked, 1);
    prog_i.frame(8'hC7, 8);
    prog_i.frame({8'h02, 24'h000000, 8'h11}, 40);
    chk({acc, 39'(cmd_q.size() + wr_q.size())}, {1'b1, 39'h0});
    @(negedge sys_clk_i);
    {sec, me_dis, bd_dis} = 3'h0;
    prog_i.frame(8'h40, 8);
    chk({acc, priv}, 0);
    @(negedge sys_clk_i);
    blank = 1'b1;
    halt = 1'b0;
    n = 0;
    repeat (30) begin
      @(negedge sys_clk_i);
      if (lockup === 1'b1) n++;
    end
    chk(40'(n >= 2 && n <= 4), 1);
    halt = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    n = 0;
    repeat (30) begin
      @(negedge sys_clk_i);
      if (lockup === 1'b1) n++;
    end
    chk(40'(n), 0);
    summarize();
  end
endmodule
